// ---- rtl/ssv_regs.vh ----
// register offsets, fields, commands and codes of the serial status block
`ifndef SSV_REGS_VH
`define SSV_REGS_VH
// ----------------------------------------------------------------------
// bus offsets (byte addresses, low byte of haddr)
// ----------------------------------------------------------------------
`define SSV_OFS_CTL_A 8'h00
`define SSV_OFS_DAT_A 8'h04
`define SSV_OFS_CTL_B 8'h08
`define SSV_OFS_DAT_B 8'h0c
// ----------------------------------------------------------------------
// pointer values and commands of command_pointer_reg
// ----------------------------------------------------------------------
`define SSV_PTR_W 3
`define SSV_PTR_MAIN 3'h0
`define SSV_PTR_ERR 3'h1
`define SSV_PTR_VEC 3'h2
`define SSV_CMD_LO 3
`define SSV_CMD_HI 5
`define SSV_CMD_EXT_RST 3'h2
`define SSV_CMD_ERR_RST 3'h6
// ----------------------------------------------------------------------
// main_status_reg and error_status_reg bits
// ----------------------------------------------------------------------
`define SSV_ST_RXAV 0
`define SSV_ST_TXE 2
`define SSV_ST_DCD 3
`define SSV_ST_EXTC 5
`define SSV_ST_BRK 7
`define SSV_ER_PAR 4
`define SSV_ER_OVR 5
`define SSV_ER_FRM 6
// ----------------------------------------------------------------------
// irq_control_reg fields and receive interrupt modes
// ----------------------------------------------------------------------
`define SSV_IC_EXT 0
`define SSV_IC_SAV 1
`define SSV_IC_TXE 2
`define SSV_IC_RXM_LO 3
`define SSV_IC_RXM_HI 4
`define SSV_RXM_OFF 2'h0
`define SSV_RXM_PAR_SPC 2'h1
`define SSV_RXM_PAR_OFF 2'h2
// ----------------------------------------------------------------------
// pending source index and vector type codes
// ----------------------------------------------------------------------
`define SSV_P_SRC 0
`define SSV_P_RXC 1
`define SSV_P_TXE 2
`define SSV_P_EXT 3
`define SSV_VEC_LO 1
`define SSV_VEC_HI 3
`define SSV_CODE_A_SRC 3'h7
`define SSV_CODE_A_RXC 3'h6
`define SSV_CODE_A_TXE 3'h4
`define SSV_CODE_A_EXT 3'h5
`define SSV_CODE_B_SRC 3'h3
`define SSV_CODE_B_RXC 3'h2
`define SSV_CODE_B_TXE 3'h0
`define SSV_CODE_B_EXT 3'h1
`define SSV_RST_BYTE 8'h00
`define SSV_HTRANS_NONSEQ 2'h2
`endif

// ---- rtl/ssv_chan.v ----
// one serial channel: receive holding byte, error latches, line change latch, transmit empty
`timescale 1ns/100ps
`default_nettype none
`include "ssv_regs.vh"
module ssv_chan (
    input wire hclk,
    input wire hresetn,
    input wire dcd_pin,
    input wire brk_in,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire rx_frm,
    input wire rx_par,
    input wire tx_done,
    input wire rd_data,
    input wire wr_data,
    input wire wr_ictl,
    input wire ext_reset,
    input wire err_reset,
    input wire [7:0] wdata,
    output wire [7:0] status,
    output wire [7:0] errs,
    output wire [7:0] rx_data,
    output wire [7:0] tx_byte,
    output wire tx_start,
    output wire sav,
    output wire [3:0] pend
);
    reg dcd_s1_ff, dcd_s2_ff, ext_chg_ff, dcd_lat_ff, brk_lat_ff;
    reg rx_av_ff, frm_ff, chr_par_ff, par_ff, ovr_ff, txe_ff, tx_go_ff;
    reg [7:0] rx_data_ff, tx_byte_ff, ictl_ff;
    wire change = (dcd_s2_ff != dcd_lat_ff) | (brk_in != brk_lat_ff);
    wire [1:0] rxm = ictl_ff[`SSV_IC_RXM_HI:`SSV_IC_RXM_LO];
    wire chr_err = frm_ff | ovr_ff | (chr_par_ff & (rxm == `SSV_RXM_PAR_SPC));
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dcd_s1_ff <= 1'b0;
            dcd_s2_ff <= 1'b0;
            ext_chg_ff <= 1'b0;
            dcd_lat_ff <= 1'b0;
            brk_lat_ff <= 1'b0;
            rx_av_ff <= 1'b0;
            frm_ff <= 1'b0;
            chr_par_ff <= 1'b0;
            par_ff <= 1'b0;
            ovr_ff <= 1'b0;
            txe_ff <= 1'b1;
            tx_go_ff <= 1'b0;
            rx_data_ff <= `SSV_RST_BYTE;
            tx_byte_ff <= `SSV_RST_BYTE;
            ictl_ff <= `SSV_RST_BYTE;
        end else begin
            dcd_s1_ff <= dcd_pin;
            dcd_s2_ff <= dcd_s1_ff;
            // a change during the latch is lost; the reset command loads the latches with the current line levels
            if (!ext_chg_ff && change) begin
                ext_chg_ff <= 1'b1;
                dcd_lat_ff <= dcd_s2_ff;
                brk_lat_ff <= brk_in;
            end else if (ext_reset) begin
                ext_chg_ff <= 1'b0;
                dcd_lat_ff <= dcd_s2_ff;
                brk_lat_ff <= brk_in;
            end
            if (rx_valid) begin
                rx_av_ff <= 1'b1;
                rx_data_ff <= rx_byte;
                frm_ff <= rx_frm;
                chr_par_ff <= rx_par;
            end else if (rd_data) begin
                rx_av_ff <= 1'b0;
            end
            par_ff <= (rx_valid & rx_par) | (par_ff & ~err_reset);
            ovr_ff <= (rx_valid & rx_av_ff & ~rd_data) | (ovr_ff & ~err_reset);
            if (wr_ictl)
                ictl_ff <= wdata;
            tx_go_ff <= wr_data & txe_ff;
            if (wr_data && txe_ff) begin
                txe_ff <= 1'b0;
                tx_byte_ff <= wdata;
            end else if (tx_done) begin
                txe_ff <= 1'b1;
            end
        end
    end
    assign status = {brk_lat_ff, 1'b0, ext_chg_ff, 1'b0, dcd_lat_ff, txe_ff, 1'b0, rx_av_ff};
    assign errs = {1'b0, frm_ff, ovr_ff, par_ff, 4'h0};
    assign rx_data = rx_data_ff;
    assign tx_byte = tx_byte_ff;
    assign tx_start = tx_go_ff;
    assign sav = ictl_ff[`SSV_IC_SAV];
    assign pend[`SSV_P_SRC] = rx_av_ff & (rxm != `SSV_RXM_OFF) & chr_err;
    assign pend[`SSV_P_RXC] = rx_av_ff & (rxm != `SSV_RXM_OFF) & ~chr_err;
    assign pend[`SSV_P_TXE] = txe_ff & ictl_ff[`SSV_IC_TXE];
    assign pend[`SSV_P_EXT] = ext_chg_ff & ictl_ff[`SSV_IC_EXT];
endmodule
`default_nettype wire

// ---- rtl/ssv_prio.v ----
// fixed priority resolver and type code for the shared vector
`timescale 1ns/100ps
`default_nettype none
`include "ssv_regs.vh"
module ssv_prio (
    input wire [3:0] pend_a,
    input wire [3:0] pend_b,
    output reg any,
    output reg [2:0] code
);
    always @* begin
        any = 1'b1;
        code = `SSV_CODE_B_TXE;
        // receive sources are exclusive per channel, so they share one rank
        if (pend_a[`SSV_P_SRC])
            code = `SSV_CODE_A_SRC;
        else if (pend_a[`SSV_P_RXC])
            code = `SSV_CODE_A_RXC;
        else if (pend_a[`SSV_P_TXE])
            code = `SSV_CODE_A_TXE;
        else if (pend_a[`SSV_P_EXT])
            code = `SSV_CODE_A_EXT;
        else if (pend_b[`SSV_P_SRC])
            code = `SSV_CODE_B_SRC;
        else if (pend_b[`SSV_P_RXC])
            code = `SSV_CODE_B_RXC;
        else if (pend_b[`SSV_P_TXE])
            code = `SSV_CODE_B_TXE;
        else if (pend_b[`SSV_P_EXT])
            code = `SSV_CODE_B_EXT;
        else
            any = 1'b0;
    end
endmodule
`default_nettype wire

// ---- rtl/ssv_top.v ----
// two-channel serial status and vectored interrupt block behind an AHB-Lite slave
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "ssv_regs.vh"
module ssv_top #(
    parameter CHANS = 2
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    input wire [1:0] dcd_pin,
    input wire [1:0] brk_in,
    input wire [1:0] rx_valid,
    input wire [15:0] rx_byte,
    input wire [1:0] rx_frm,
    input wire [1:0] rx_par,
    input wire [1:0] tx_done,
    output wire [15:0] tx_byte,
    output wire [1:0] tx_start,
    output wire irq_req,
    output wire [7:0] irq_vector
);
    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // bit 0 control hit, bit 1 data hit, bit 2 second channel
    function [2:0] ssv_dec;
        input [7:0] ofs;
        begin
            case (ofs)
                `SSV_OFS_CTL_A: ssv_dec = 3'h1;
                `SSV_OFS_DAT_A: ssv_dec = 3'h2;
                `SSV_OFS_CTL_B: ssv_dec = 3'h5;
                `SSV_OFS_DAT_B: ssv_dec = 3'h6;
                default: ssv_dec = 3'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // bus state
    // ------------------------------------------------------------------
    localparam ST_IDLE = 3'h1;
    localparam ST_WR = 3'h2;
    localparam ST_RD = 3'h4;
    reg [2:0] st_ff, nxt_st;
    reg [7:0] ofs_ff;
    reg [31:0] hrdata_ff;
    reg [7:0] vec_ff;
    reg [7:0] vec_out_ff;
    wire acc = hsel & (htrans == `SSV_HTRANS_NONSEQ) & hready;
    wire [2:0] dec = ssv_dec(ofs_ff);
    wire wr_ph = (st_ff == ST_WR);
    wire rd_ph = (st_ff == ST_RD);
    wire [1:0] ctl_hit;
    wire [1:0] dat_hit;
    wire [7:0] rd_byte_a, rd_byte_b;
    wire [3:0] pend_a, pend_b;
    wire [1:0] sav;
    wire [2:0] ptr_b;
    wire prio_any;
    wire [2:0] prio_code;
    wire [7:0] vec_mod;

    // reads take one wait cycle so a pointer write just before is seen
    assign hreadyout = ~rd_ph;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign ctl_hit = {dec[2] & dec[0], ~dec[2] & dec[0]};
    assign dat_hit = {dec[2] & dec[1], ~dec[2] & dec[1]};

    always @* begin
        case (st_ff)
            ST_IDLE: nxt_st = acc ? (hwrite ? ST_WR : ST_RD) : ST_IDLE;
            ST_WR: nxt_st = acc ? (hwrite ? ST_WR : ST_RD) : ST_IDLE;
            ST_RD: nxt_st = ST_IDLE;
            default: nxt_st = ST_IDLE;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= ST_IDLE;
            ofs_ff <= `SSV_RST_BYTE;
        end else begin
            st_ff <= nxt_st;
            if (acc)
                ofs_ff <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------------
    // channels with their register pointers
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < CHANS; gi = gi + 1) begin : g_ch
            reg [`SSV_PTR_W-1:0] ptr_ff;
            reg [7:0] rd_byte;
            wire [7:0] status, errs, rx_data;
            wire [3:0] pend;
            wire wctl = wr_ph & ctl_hit[gi];
            wire rctl = rd_ph & ctl_hit[gi];
            wire at_main = (ptr_ff == `SSV_PTR_MAIN);
            wire [2:0] cmd = hwdata[`SSV_CMD_HI:`SSV_CMD_LO];
            wire ext_rst = wctl & at_main & (cmd == `SSV_CMD_EXT_RST);
            wire err_rst = wctl & at_main & (cmd == `SSV_CMD_ERR_RST);
            wire wr_ictl = wctl & (ptr_ff == `SSV_PTR_ERR);

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ptr_ff <= `SSV_PTR_MAIN;
                end else if (wctl && at_main) begin
                    ptr_ff <= hwdata[`SSV_PTR_W-1:0];
                end else if (wctl || rctl) begin
                    ptr_ff <= `SSV_PTR_MAIN;
                end
            end

            always @* begin
                case (ptr_ff)
                    `SSV_PTR_MAIN: rd_byte = status;
                    `SSV_PTR_ERR: rd_byte = errs;
                    // only the second channel answers with the vector
                    `SSV_PTR_VEC: rd_byte = (gi == 1) ? vec_mod : `SSV_RST_BYTE;
                    default: rd_byte = `SSV_RST_BYTE;
                endcase
            end

            ssv_chan u_chan (
                .hclk(hclk),
                .hresetn(hresetn),
                .dcd_pin(dcd_pin[gi]),
                .brk_in(brk_in[gi]),
                .rx_valid(rx_valid[gi]),
                .rx_byte(rx_byte[gi*8+7:gi*8]),
                .rx_frm(rx_frm[gi]),
                .rx_par(rx_par[gi]),
                .tx_done(tx_done[gi]),
                .rd_data(rd_ph & dat_hit[gi]),
                .wr_data(wr_ph & dat_hit[gi]),
                .wr_ictl(wr_ictl),
                .ext_reset(ext_rst),
                .err_reset(err_rst),
                .wdata(hwdata[7:0]),
                .status(status),
                .errs(errs),
                .rx_data(rx_data),
                .tx_byte(tx_byte[gi*8+7:gi*8]),
                .tx_start(tx_start[gi]),
                .sav(sav[gi]),
                .pend(pend)
            );
        end
    endgenerate

    assign rd_byte_a = dat_hit[0] ? g_ch[0].rx_data : g_ch[0].rd_byte;
    assign rd_byte_b = dat_hit[1] ? g_ch[1].rx_data : g_ch[1].rd_byte;
    assign pend_a = g_ch[0].pend;
    assign pend_b = g_ch[1].pend;
    assign ptr_b = g_ch[1].ptr_ff;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // unmapped offsets read zero and ignore writes, answer stays okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_ph) begin
            if (dec[2])
                hrdata_ff <= {24'h00_0000, rd_byte_b};
            else if (dec[1] || dec[0])
                hrdata_ff <= {24'h00_0000, rd_byte_a};
            else
                hrdata_ff <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // shared vector and priority
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vec_ff <= `SSV_RST_BYTE;
        end else if (wr_ph && ctl_hit[1] && ptr_b == `SSV_PTR_VEC) begin
            vec_ff <= hwdata[7:0];
        end
    end

    ssv_prio u_prio (
        .pend_a(pend_a),
        .pend_b(pend_b),
        .any(prio_any),
        .code(prio_code)
    );

    // without a pending source the stored vector is shown unchanged
    assign vec_mod = (sav[1] && prio_any) ?
        {vec_ff[7:`SSV_VEC_HI+1], prio_code, vec_ff[`SSV_VEC_LO-1:0]} : vec_ff;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            vec_out_ff <= `SSV_RST_BYTE;
        else
            vec_out_ff <= vec_mod;
    end

    assign irq_req = prio_any;
    assign irq_vector = vec_out_ff;
endmodule
`default_nettype wire

// ---- verification/ssv_link_model.sv ----
// serializer stand-in: takes each byte and reports it sent after a delay
`timescale 1ns/100ps
`default_nettype none
module ssv_link_model #(
    parameter int DLY = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] tx_start,
    output logic [1:0] tx_done
);
// ----------------------------------------------------------------------
// per channel send timer; slow on purpose so tx-empty is seen low
// ----------------------------------------------------------------------
logic [3:0] cnt_ff [2];
logic [1:0] done_ff;
assign tx_done = done_ff;
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cnt_ff[0] <= 4'h0;
        cnt_ff[1] <= 4'h0;
        done_ff <= 2'h0;
    end else begin
        for (int i = 0; i < 2; i++) begin
            done_ff[i] <= (cnt_ff[i] == 4'h1);
            if (tx_start[i]) begin
                cnt_ff[i] <= DLY[3:0];
            end else if (cnt_ff[i] != 4'h0) begin
                cnt_ff[i] <= cnt_ff[i] - 4'h1;
            end
        end
    end
end
endmodule
`default_nettype wire

// ---- verification/ssv_checker.sv ----
// port assertions for the serial status and vector block
`timescale 1ns/100ps
`default_nettype none
module ssv_checker #(
    parameter CHANS = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [1:0] tx_start,
    input wire logic irq_req,
    input wire logic [7:0] irq_vector
);
// ----------------------------------------------------------------------
// bus, link and interrupt reset checks
// ----------------------------------------------------------------------
default clocking @(posedge hclk);
endclocking
default disable iff (!hresetn);
logic rd_take;
logic wr_take;
assign rd_take = hsel && htrans == 2'h2 && hready && !hwrite;
assign wr_take = hsel && htrans == 2'h2 && hready && hwrite;
a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
a_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write was stalled");
a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait without a read");
a_rdata_hold: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data moved outside a read");
a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
a_txs_pulse: assert property ((tx_start & $past(tx_start)) == 2'h0)
    else $error("send pulse longer than one cycle");
// a send pulse follows the data phase of an accepted write, never on its own
a_send_cause: assert property (|tx_start |-> $past(wr_take, 2))
    else $error("send pulse without a write");
a_irq_reset: assert property ($rose(hresetn) |-> !irq_req && irq_vector == 8'h00)
    else $error("interrupt state not clear after reset");
c_read: cover property (rd_take);
c_send: cover property (tx_start[0]);
c_irq: cover property (irq_req);
endmodule
bind ssv_top ssv_checker #(.CHANS(CHANS)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tx_start(tx_start), .irq_req(irq_req), .irq_vector(irq_vector));
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the serial status and vector block
`timescale 1ns/100ps
`default_nettype none
`include "ssv_regs.vh"
module testbench;
// ----------------------------------------------------------------------
// signals, clock, instances
// ----------------------------------------------------------------------
localparam logic [7:0] OCA = `SSV_OFS_CTL_A;
localparam logic [7:0] ODA = `SSV_OFS_DAT_A;
localparam logic [7:0] OCB = `SSV_OFS_CTL_B;
localparam logic [7:0] ODB = `SSV_OFS_DAT_B;
logic hclk = 1'b0;
logic hresetn = 1'b0;
logic hsel = 1'b0;
logic hwrite = 1'b0;
logic [1:0] htrans = 2'h0;
logic [31:0] haddr = 32'h0;
logic [31:0] hwdata = 32'h0;
logic [1:0] dcd_pin = 2'h0;
logic [1:0] brk_in = 2'h0;
logic [1:0] rx_valid = 2'h0;
logic [1:0] rx_frm = 2'h0;
logic [1:0] rx_par = 2'h0;
logic [15:0] rx_byte = 16'h0;
logic hreadyout;
logic hresp;
logic [31:0] hrdata;
logic [15:0] tx_byte;
logic [1:0] tx_start;
logic [1:0] tx_done;
logic irq_req;
logic [7:0] irq_vector;
logic [7:0] q;
int n_fail = 0;
int checked = 0;
always #25 hclk = ~hclk;
ssv_top #(.CHANS(2)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dcd_pin(dcd_pin), .brk_in(brk_in), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_frm(rx_frm), .rx_par(rx_par), .tx_done(tx_done), .tx_byte(tx_byte),
    .tx_start(tx_start), .irq_req(irq_req), .irq_vector(irq_vector));
ssv_link_model #(.DLY(12)) i_link (.hclk(hclk), .hresetn(hresetn), .tx_start(tx_start), .tx_done(tx_done));
// ----------------------------------------------------------------------
// tasks
// ----------------------------------------------------------------------
task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask
task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
        n_fail++;
        $display("BAD %s expected %h seen %h", nm, e, g);
    end
endtask
// ready is looked at late in the cycle, where it is settled for the edge
task automatic wait_rdy(output logic [7:0] r);
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
        n++;
        if (n > 50) begin
            n_fail++;
            final_report();
        end
        @(negedge hclk);
    end
    r = hrdata[7:0];
    @(posedge hclk);
endtask
task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `SSV_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy(r);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_rdy(r);
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, r);
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] r);
    bus(a, 1'b0, 8'h00, r);
endtask
task automatic setreg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] v);
    wr(a, p);
    wr(a, v);
endtask
task automatic getreg(input logic [7:0] a, input logic [7:0] p, output logic [7:0] r);
    if (p != 8'h00) begin
        wr(a, p);
    end
    rd(a, r);
endtask
task automatic rx(input int ch, input logic [7:0] b, input logic f, input logic p);
    rx_valid[ch] <= 1'b1;
    rx_byte[ch*8 +: 8] <= b;
    rx_frm[ch] <= f;
    rx_par[ch] <= p;
    @(posedge hclk);
    rx_valid <= 2'h0;
    rx_frm <= 2'h0;
    rx_par <= 2'h0;
    @(posedge hclk);
endtask
task automatic idle(input int n);
    repeat (n) @(posedge hclk);
endtask
// vector base 8'hf1 has bits 3:1 clear, so the code simply ors in
task automatic vec(input logic [2:0] c);
    logic [7:0] r;
    getreg(OCB, 8'h02, r);
    chk("vector_status", 8'hf1 | {4'h0, c, 1'b0}, r);
    chk("irq_vector", 8'hf1 | {4'h0, c, 1'b0}, irq_vector);
    chk("irq_req", 8'h01, {7'h0, irq_req});
endtask
// ----------------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------------
initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OCA, q);
    chk("main_a", 8'h04, q & 8'h05);
    rd(8'h10, q);
    chk("unmapped", 8'h00, q);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    $display("test reset done");
    rx(0, 8'h11, 1'b1, 1'b1);
    rd(OCA, q);
    chk("main_a", 8'h01, q & 8'h01);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    getreg(OCA, 8'h01, q);
    chk("err_a", 8'h50, q & 8'h70);
    rd(ODA, q);
    chk("data_a", 8'h11, q);
    rd(OCA, q);
    chk("main_a", 8'h00, q & 8'h01);
    rx(0, 8'h22, 1'b0, 1'b0);
    getreg(OCA, 8'h01, q);
    chk("err_a", 8'h10, q & 8'h70);
    rx(0, 8'h33, 1'b0, 1'b0);
    getreg(OCA, 8'h01, q);
    chk("err_a", 8'h30, q & 8'h70);
    rd(ODA, q);
    chk("data_a", 8'h33, q);
    wr(OCA, 8'h30);
    getreg(OCA, 8'h01, q);
    chk("err_a", 8'h00, q & 8'h70);
    $display("test receive done");
    wr(ODA, 8'h3c);
    wr(ODA, 8'h77);
    rd(OCA, q);
    chk("main_a", 8'h00, q & 8'h04);
    chk("tx_byte", 8'h3c, tx_byte[7:0]);
    idle(14);
    rd(OCA, q);
    chk("main_a", 8'h04, q & 8'h04);
    wr(ODB, 8'h5a);
    rd(OCB, q);
    chk("main_b", 8'h00, q & 8'h04);
    chk("tx_byte_b", 8'h5a, tx_byte[15:8]);
    $display("test transmit done");
    dcd_pin <= 2'h1;
    brk_in <= 2'h2;
    idle(6);
    rd(OCA, q);
    chk("main_a", 8'h28, q & 8'ha8);
    rd(OCB, q);
    chk("main_b", 8'ha0, q & 8'ha8);
    wr(OCA, 8'h10);
    wr(OCB, 8'h10);
    idle(2);
    rd(OCA, q);
    chk("main_a", 8'h08, q & 8'ha8);
    rd(OCB, q);
    chk("main_b", 8'h80, q & 8'ha8);
    $display("test line change done");
    setreg(OCA, 8'h02, 8'hff);
    setreg(OCB, 8'h02, 8'hf1);
    getreg(OCB, 8'h02, q);
    chk("vector_status", 8'hf1, q);
    setreg(OCB, 8'h01, 8'h02);
    // let the control write settle before looking at the request
    idle(1);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    brk_in <= 2'h0;
    idle(4);
    setreg(OCB, 8'h01, 8'h03);
    vec(3'h1);
    setreg(OCB, 8'h01, 8'h07);
    vec(3'h0);
    setreg(OCB, 8'h01, 8'h0f);
    rx(1, 8'h44, 1'b0, 1'b1);
    vec(3'h3);
    wr(OCB, 8'h30);
    rd(ODB, q);
    chk("data_b", 8'h44, q);
    rx(1, 8'h55, 1'b0, 1'b0);
    vec(3'h2);
    dcd_pin <= 2'h0;
    idle(4);
    setreg(OCA, 8'h01, 8'h01);
    vec(3'h5);
    setreg(OCA, 8'h01, 8'h05);
    vec(3'h4);
    setreg(OCA, 8'h01, 8'h0d);
    rx(0, 8'h66, 1'b0, 1'b0);
    vec(3'h6);
    rd(ODA, q);
    rx(0, 8'h77, 1'b1, 1'b0);
    vec(3'h7);
    wr(OCA, 8'h30);
    rd(ODA, q);
    setreg(OCA, 8'h01, 8'h15);
    rx(0, 8'h88, 1'b0, 1'b1);
    vec(3'h6);
    getreg(OCA, 8'h01, q);
    chk("err_a", 8'h10, q & 8'h10);
    $display("test vector done");
    hresetn <= 1'b0;
    idle(2);
    hresetn <= 1'b1;
    idle(1);
    chk("irq_req", 8'h00, {7'h0, irq_req});
    chk("irq_vector", 8'h00, irq_vector);
    rd(OCA, q);
    chk("main_a", 8'h04, q);
    $display("test second reset done");
    final_report();
end
endmodule
`default_nettype wire
